// *** design/sfc_consts.svh ***
// Purpose: Named constants of the stacked frame control block
// Assumes: Included by bare name after the package
// Notes:   Fields are part-selects of a 32-bit word
`ifndef SFC_CONSTS_SVH
`define SFC_CONSTS_SVH

// ----------------------------------------------------------------
// Register stack geometry
// ----------------------------------------------------------------
`define SFC_STATIC_N   7'h20   // First stacked logical register
`define SFC_STACK_MAX  7'h60   // Largest frame a procedure may hold
`define SFC_REG_BYTES  4'h8    // Bytes spilled per register
`define SFC_QP_TRUE    6'h00   // Hardwired-true predicate
`define SFC_LCW        16      // Width of the load-count field

// ----------------------------------------------------------------
// Register map, word index taken from adr[4:2]
// ----------------------------------------------------------------
`define SFC_A_CMD      3'h0
`define SFC_A_STAT     3'h1
`define SFC_A_CFG      3'h2
`define SFC_A_ACC      3'h3
`define SFC_A_SAVED    3'h4

// Command word fields
`define SFC_F_CODE     2:0
`define SFC_F_SOF      10:4
`define SFC_F_SOL      18:12
`define SFC_F_QP       25:20
// Status word fields
`define SFC_F_BUSY     0
`define SFC_F_FAULT    1
`define SFC_F_CSOF     14:8
`define SFC_F_CSOL     22:16
// Access word fields, then the load count of the config word
`define SFC_F_IDX      6:0
`define SFC_F_WR       8
`define SFC_F_AFLT     9
`define SFC_F_LOADCNT  15:0

`endif

// *** design/sfc_pkg.sv ***
// Purpose: Types shared by both ends of the frame control link
// Assumes: Nothing
// Notes:   Modulo add serves renaming and frame movement
package sfc_pkg;
	typedef enum logic [2:0] {
		SFC_OP_ALLOC  = 3'h0,
		SFC_OP_CALL   = 3'h1,
		SFC_OP_RET    = 3'h2,
		SFC_OP_COVER  = 3'h3,
		SFC_OP_FLUSH  = 3'h4,
		SFC_OP_LOAD   = 3'h5,
		SFC_OP_CLRRRB = 3'h6,
		SFC_OP_SETPFM = 3'h7
	} sfc_op_e;

	typedef enum logic [1:0] {
		SFC_ST_IDLE = 2'h0,
		SFC_ST_ENG  = 2'h1
	} sfc_state_e;

	typedef enum logic {
		SFC_ENG_SPILL = 1'b0,
		SFC_ENG_FILL  = 1'b1
	} sfc_eng_e;

	typedef struct packed {
		logic [6:0] sof;
		logic [6:0] sol;
	} sfc_frame_s;

	// Add modulo n, both operands below n
	function automatic logic [6:0] sfc_mod_add(logic [6:0] a, logic [6:0] b, logic [6:0] n);
		logic [7:0] s;
		s = {1'b0, a} + {1'b0, b};
		return (s >= {1'b0, n}) ? 7'(s - {1'b0, n}) : s[6:0];
	endfunction
endpackage

// *** design/sfc_link_if.sv ***
// Purpose: Link between issue pipeline end and frame control end
// Assumes: One clock for both ends
// Notes:   No clocking block; the bench joins the two ends
`timescale 1ns/1ps
`default_nettype none
interface sfc_link_if
	import sfc_pkg::*;
	(input wire logic clk);
	logic                op_valid;
	sfc_op_e             op_code;
	sfc_frame_s          op_frame;
	logic [5:0]          op_qp;
	logic                op_ready;
	logic                op_done;
	logic                op_fault;
	logic                acc_valid;
	logic                acc_write;
	logic [6:0]          acc_idx;
	logic                acc_done;
	logic                acc_fault;
	logic [6:0]          acc_phys;
	logic                eng_req;
	sfc_eng_e            eng_kind;
	logic [15:0]         eng_bytes;
	logic                eng_done;
	logic [15:0]         load_count;
	sfc_frame_s          cur;
	sfc_frame_s          saved;

	modport dev (input op_valid, op_code, op_frame, op_qp, acc_valid, acc_write, acc_idx,
		eng_done, load_count, output op_ready, op_done, op_fault, acc_done, acc_fault,
		acc_phys, eng_req, eng_kind, eng_bytes, cur, saved);
	modport ctl (output op_valid, op_code, op_frame, op_qp, acc_valid, acc_write, acc_idx,
		eng_done, load_count, input op_ready, op_done, op_fault, acc_done, acc_fault,
		acc_phys, eng_req, eng_kind, eng_bytes, cur, saved);
endinterface // sfc_link_if
`default_nettype wire

// *** design/sfc_rename.sv ***
// Purpose: Logical to physical general register mapping
// Assumes: Base below PHYS_N, frame no larger than the stack maximum
// Notes:   Pure combinational, used by the frame control end
`timescale 1ns/1ps
`default_nettype none
`include "sfc_consts.svh"
module sfc_rename
	import sfc_pkg::*;
	#(parameter logic [6:0] PHYS_N = 7'h60)
	(
	input  wire logic [6:0] base,
	input  wire logic [6:0] idx,
	input  wire logic [6:0] sof,
	output logic [6:0]      phys,
	output logic            stacked,
	output logic            in_frame
	);
	logic [6:0] rel;

	// ----------------------------------------------------------------
	// Rename through a rotating base
	// ----------------------------------------------------------------
	always_comb begin
		stacked  = idx >= `SFC_STATIC_N;
		rel      = stacked ? 7'(idx - `SFC_STATIC_N) : 7'h00;
		in_frame = !stacked || (rel < sof);
		phys     = stacked ? sfc_mod_add(base, rel, PHYS_N) : idx;
	end
endmodule // sfc_rename
`default_nettype wire

// *** design/sfc_frame_dev.sv ***
// Purpose: Stacked register frame control (device end)
// Assumes: One op at a time from the issue end; engine done is a pulse
// Notes:   Rotating base of modulo-scheduled loops is not modelled
// Behaviour
// - Call gives empty locals, shared outputs
// - Output area is total minus locals
// - Current descriptor holds total and locals
// - Out-of-frame write faults, read undefined
// - Call saves current descriptor first
// - Call renames caller output to 32
// - Allocate resizes only, no renaming
// - Allocate leaves values and tags alone
// - Return restores descriptor and renaming
// - Descriptor changes only on frame ops
// - Allocate comes first in its group
// - Allocate frame applies to own group
// - Allocate under other predicate faults
// - Flush stalls until old frames spilled
// - Flush first in group, unpredicated
// - Cover makes empty frame above current
// - Cover last in group, unpredicated
// - Load stalls until count bytes filled
// - Zero count refills all, no writeback
// - Load first in group, unpredicated
// - Software keeps saved descriptor across calls
// - Static 0..31, stacked up to 96
//
// Design decisions made here: the Wishbone register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "sfc_consts.svh"
module sfc_frame_dev
	import sfc_pkg::*;
	#(parameter logic [6:0] PHYS_N = 7'h60)
	(
	input  wire logic  MCLK,
	input  wire logic  RST,
	input  wire logic  CE,
	sfc_link_if.dev    LINK,
	output logic [6:0] PHYS_ADDR,
	output logic       PHYS_STACKED,
	output logic       PHYS_WE,
	output logic       PHYS_RE
	);

	// ----------------------------------------------------------------
	// Parameter check
	// ----------------------------------------------------------------
	if (PHYS_N < `SFC_STACK_MAX || PHYS_N == 7'h7f) begin : g_bad_phys
		$error("PHYS_N must lie between 96 and 126");
	end

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	sfc_state_e  state_q,     state_d;
	sfc_frame_s  cfm_q,       cfm_d;
	sfc_frame_s  pfm_q,       pfm_d;
	logic [6:0]  base_q,      base_d;
	logic [6:0]  dirty_q,     dirty_d;
	logic        done_q,      done_d;
	logic        fault_q,     fault_d;
	logic        eng_req_q,   eng_req_d;
	sfc_eng_e    eng_kind_q,  eng_kind_d;
	logic [15:0] eng_bytes_q, eng_bytes_d;
	logic        acc_done_q,  acc_fault_q;
	logic [6:0]  acc_phys_q;
	logic        stk_q,       we_q,     re_q;
	logic        acc_fault_d, we_d,     re_d;
	logic [6:0]  ren_phys;
	logic        ren_stk,     ren_in;
	logic        take;

	// Saturating add for the unspilled register count
	function automatic logic [6:0] sat_add(logic [6:0] a, logic [6:0] b);
		logic [7:0] s;
		s = {1'b0, a} + {1'b0, b};
		return (s > {1'b0, PHYS_N}) ? PHYS_N : s[6:0];
	endfunction

	// Ops are taken only while idle; engine ops stall the issue end
	assign take = LINK.op_valid && LINK.op_ready;
	assign LINK.op_ready = CE && (state_q == SFC_ST_IDLE);

	// ----------------------------------------------------------------
	// Frame operations
	// ----------------------------------------------------------------
	always_comb begin
		state_d     = state_q;
		cfm_d       = cfm_q;
		pfm_d       = pfm_q;
		base_d      = base_q;
		dirty_d     = dirty_q;
		done_d      = 1'b0;
		fault_d     = 1'b0;
		eng_req_d   = eng_req_q;
		eng_kind_d  = eng_kind_q;
		eng_bytes_d = eng_bytes_q;
		unique case (state_q)
			SFC_ST_IDLE: begin
				if (take) begin
					done_d = 1'b1;
					unique case (LINK.op_code)
						SFC_OP_ALLOC: begin
							// New sizes only; base and register contents untouched
							if (LINK.op_qp != `SFC_QP_TRUE) begin
								fault_d = 1'b1;
							end else if (LINK.op_frame.sol > LINK.op_frame.sof
								|| LINK.op_frame.sof > `SFC_STACK_MAX) begin
								fault_d = 1'b1;
							end else begin
								cfm_d = LINK.op_frame;
							end
						end
						SFC_OP_CALL: begin
							pfm_d       = cfm_q;
							base_d      = sfc_mod_add(base_q, cfm_q.sol, PHYS_N);
							dirty_d     = sat_add(dirty_q, cfm_q.sol);
							cfm_d.sof   = 7'(cfm_q.sof - cfm_q.sol);
							cfm_d.sol   = 7'h00;
						end
						SFC_OP_RET: begin
							cfm_d   = pfm_q;
							base_d  = sfc_mod_add(base_q, 7'(PHYS_N - pfm_q.sol), PHYS_N);
							dirty_d = (dirty_q > pfm_q.sol) ? 7'(dirty_q - pfm_q.sol) : 7'h00;
						end
						SFC_OP_COVER: begin
							// Whole frame left below the new empty one
							base_d  = sfc_mod_add(base_q, cfm_q.sof, PHYS_N);
							dirty_d = sat_add(dirty_q, cfm_q.sof);
							cfm_d   = '0;
						end
						SFC_OP_FLUSH: begin
							done_d      = 1'b0;
							state_d     = SFC_ST_ENG;
							eng_req_d   = 1'b1;
							eng_kind_d  = SFC_ENG_SPILL;
							eng_bytes_d = 16'(dirty_q) * 16'(`SFC_REG_BYTES);
						end
						SFC_OP_LOAD: begin
							done_d      = 1'b0;
							state_d     = SFC_ST_ENG;
							eng_req_d   = 1'b1;
							eng_kind_d  = SFC_ENG_FILL;
							eng_bytes_d = LINK.load_count;
						end
						SFC_OP_SETPFM: begin
							pfm_d = LINK.op_frame;
						end
						default: begin
							// Clear of the rotating base: frame sizes kept
						end
					endcase
				end
			end
			SFC_ST_ENG: begin
				if (LINK.eng_done) begin
					state_d   = SFC_ST_IDLE;
					eng_req_d = 1'b0;
					done_d    = 1'b1;
					// Nothing below the frame is left to write back
					dirty_d   = 7'h00;
				end
			end
			default: begin
				state_d   = SFC_ST_IDLE;
				eng_req_d = 1'b0;
			end
		endcase
	end

	// Descriptor, base and handshake flops; held while CE is low
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			state_q     <= SFC_ST_IDLE;
			cfm_q       <= '0;
			pfm_q       <= '0;
			base_q      <= 7'h00;
			dirty_q     <= 7'h00;
			done_q      <= 1'b0;
			fault_q     <= 1'b0;
			eng_req_q   <= 1'b0;
			eng_kind_q  <= SFC_ENG_SPILL;
			eng_bytes_q <= 16'h0000;
		end else if (CE) begin
			state_q     <= state_d;
			cfm_q       <= cfm_d;
			pfm_q       <= pfm_d;
			base_q      <= base_d;
			dirty_q     <= dirty_d;
			done_q      <= done_d;
			fault_q     <= fault_d;
			eng_req_q   <= eng_req_d;
			eng_kind_q  <= eng_kind_d;
			eng_bytes_q <= eng_bytes_d;
		end
	end

	// ----------------------------------------------------------------
	// Register access check
	// ----------------------------------------------------------------
	// Next frame is used, so an allocate covers its own group
	sfc_rename #(.PHYS_N(PHYS_N)) u_rename (
		.base     (base_d),
		.idx      (LINK.acc_idx),
		.sof      (cfm_d.sof),
		.phys     (ren_phys),
		.stacked  (ren_stk),
		.in_frame (ren_in)
	);

	// Writes outside the frame fault; reads pass with any value
	always_comb begin
		acc_fault_d = LINK.acc_valid && LINK.acc_write && !ren_in;
		we_d        = LINK.acc_valid && LINK.acc_write && ren_in;
		re_d        = LINK.acc_valid && !LINK.acc_write;
	end

	// Access result flops
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			acc_done_q  <= 1'b0;
			acc_fault_q <= 1'b0;
			acc_phys_q  <= 7'h00;
			stk_q       <= 1'b0;
			we_q        <= 1'b0;
			re_q        <= 1'b0;
		end else if (CE) begin
			acc_done_q  <= LINK.acc_valid;
			acc_fault_q <= acc_fault_d;
			we_q        <= we_d;
			re_q        <= re_d;
			if (LINK.acc_valid) begin
				acc_phys_q <= ren_phys;
				stk_q      <= ren_stk;
			end
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign LINK.op_done   = done_q;
	assign LINK.op_fault  = fault_q;
	assign LINK.acc_done  = acc_done_q;
	assign LINK.acc_fault = acc_fault_q;
	assign LINK.acc_phys  = acc_phys_q;
	assign LINK.eng_req   = eng_req_q;
	assign LINK.eng_kind  = eng_kind_q;
	assign LINK.eng_bytes = eng_bytes_q;
	assign LINK.cur       = cfm_q;
	assign LINK.saved     = pfm_q;
	assign PHYS_ADDR      = acc_phys_q;
	assign PHYS_STACKED   = stk_q;
	assign PHYS_WE        = we_q;
	assign PHYS_RE        = re_q;
endmodule // sfc_frame_dev
`default_nettype wire

// *** design/sfc_issue_host.sv ***
// Purpose: Issue end: Wishbone registers driving the frame link
// Assumes: Classic Wishbone, one outstanding op or access
// Notes:   Command and access words launch on write; busy drops on done
`timescale 1ns/1ps
`default_nettype none
`include "sfc_consts.svh"
module sfc_issue_host
	import sfc_pkg::*;
	(
	input  wire logic        MCLK,
	input  wire logic        RST,
	input  wire logic        CE,
	input  wire logic [31:0] WB_ADR_I,
	input  wire logic [31:0] WB_DAT_I,
	output logic [31:0]      WB_DAT_O,
	input  wire logic [3:0]  WB_SEL_I,
	input  wire logic        WB_WE_I,
	input  wire logic        WB_STB_I,
	input  wire logic        WB_CYC_I,
	output logic             WB_ACK_O,
	output logic             ENG_REQ,
	output logic             ENG_KIND,
	output logic [15:0]      ENG_BYTES,
	input  wire logic        ENG_DONE,
	sfc_link_if.ctl          LINK
	);
	logic        ack_q,   ack_d;
	logic [31:0] rd_q,    rd_d;
	logic [15:0] cfg_q,   cfg_d;
	logic        opv_q,   opv_d;
	logic        busy_q,  busy_d;
	logic        flt_q,   flt_d;
	logic [31:0] cmd_q,   cmd_d;
	logic        accv_q,  accv_d;
	logic        accb_q,  accb_d;
	logic [9:0]  accw_q,  accw_d;
	logic        ereq_q,  ekind_q;
	logic [15:0] ebytes_q;
	logic        hit;
	logic [2:0]  widx;

	assign hit  = WB_CYC_I && WB_STB_I && !ack_q;
	assign widx = WB_ADR_I[4:2];

	// ----------------------------------------------------------------
	// Bus slave and launch logic
	// ----------------------------------------------------------------
	always_comb begin
		ack_d  = hit;
		rd_d   = rd_q;
		cfg_d  = cfg_q;
		cmd_d  = cmd_q;
		opv_d  = opv_q && !LINK.op_ready;
		busy_d = busy_q && !LINK.op_done;
		flt_d  = LINK.op_done ? LINK.op_fault : flt_q;
		accv_d = 1'b0;
		accb_d = accb_q && !LINK.acc_done;
		accw_d = accw_q;
		if (LINK.acc_done) begin
			accw_d[`SFC_F_IDX]  = LINK.acc_phys;
			accw_d[`SFC_F_AFLT] = LINK.acc_fault;
		end
		if (hit) begin
			rd_d = 32'h0000_0000;
			unique case (widx)
				`SFC_A_CMD: rd_d = cmd_q;
				`SFC_A_STAT: begin
					rd_d[`SFC_F_BUSY]  = busy_q;
					rd_d[`SFC_F_FAULT] = flt_q;
					rd_d[`SFC_F_CSOF]  = LINK.cur.sof;
					rd_d[`SFC_F_CSOL]  = LINK.cur.sol;
				end
				`SFC_A_CFG: rd_d[`SFC_F_LOADCNT] = cfg_q;
				`SFC_A_ACC: rd_d[9:0] = accw_q;
				`SFC_A_SAVED: begin
					rd_d[`SFC_F_SOF] = LINK.saved.sof;
					rd_d[`SFC_F_SOL] = LINK.saved.sol;
				end
				default: rd_d = 32'h0000_0000;
			endcase
			if (WB_WE_I) begin
				unique case (widx)
					`SFC_A_CMD: begin
						// Ignored while an op is still in flight
						if (!busy_q) begin
							cmd_d  = WB_DAT_I;
							opv_d  = 1'b1;
							busy_d = 1'b1;
						end
					end
					`SFC_A_CFG: begin
						if (WB_SEL_I[0]) cfg_d[7:0]  = WB_DAT_I[7:0];
						if (WB_SEL_I[1]) cfg_d[15:8] = WB_DAT_I[15:8];
					end
					`SFC_A_ACC: begin
						if (!accb_q) begin
							accw_d[`SFC_F_IDX] = WB_DAT_I[`SFC_F_IDX];
							accw_d[`SFC_F_WR]  = WB_DAT_I[`SFC_F_WR];
							accw_d[`SFC_F_AFLT] = 1'b0;
							accv_d = 1'b1;
							accb_d = 1'b1;
						end
					end
					default: begin
						// Unmapped or read-only: write dropped
					end
				endcase
			end
		end
	end

	// Register flops; frozen while CE is low
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			ack_q    <= 1'b0;
			rd_q     <= 32'h0000_0000;
			cfg_q    <= 16'h0000;
			cmd_q    <= 32'h0000_0000;
			opv_q    <= 1'b0;
			busy_q   <= 1'b0;
			flt_q    <= 1'b0;
			accv_q   <= 1'b0;
			accb_q   <= 1'b0;
			accw_q   <= 10'h000;
			ereq_q   <= 1'b0;
			ekind_q  <= 1'b0;
			ebytes_q <= 16'h0000;
		end else if (CE) begin
			ack_q    <= ack_d;
			rd_q     <= rd_d;
			cfg_q    <= cfg_d;
			cmd_q    <= cmd_d;
			opv_q    <= opv_d;
			busy_q   <= busy_d;
			flt_q    <= flt_d;
			accv_q   <= accv_d;
			accb_q   <= accb_d;
			accw_q   <= accw_d;
			ereq_q   <= LINK.eng_req && !ENG_DONE;
			ekind_q  <= LINK.eng_kind;
			ebytes_q <= LINK.eng_bytes;
		end
	end

	// ----------------------------------------------------------------
	// Link and engine drive
	// ----------------------------------------------------------------
	assign LINK.op_valid        = opv_q;
	assign LINK.op_code         = sfc_op_e'(cmd_q[`SFC_F_CODE]);
	assign LINK.op_frame.sof    = cmd_q[`SFC_F_SOF];
	assign LINK.op_frame.sol    = cmd_q[`SFC_F_SOL];
	assign LINK.op_qp           = cmd_q[`SFC_F_QP];
	assign LINK.acc_valid       = accv_q;
	assign LINK.acc_write       = accw_q[`SFC_F_WR];
	assign LINK.acc_idx         = accw_q[`SFC_F_IDX];
	assign LINK.eng_done        = ENG_DONE && ereq_q;
	assign LINK.load_count      = cfg_q;
	assign WB_ACK_O             = ack_q;
	assign WB_DAT_O             = rd_q;
	assign ENG_REQ              = ereq_q;
	assign ENG_KIND             = ekind_q;
	assign ENG_BYTES            = ebytes_q;
endmodule // sfc_issue_host
`default_nettype wire

// *** dv/sfc_link_props.sv ***
// Purpose: Link timing checks
// Assumes: One clock, reset active high
// Notes:   Instantiated by tb
`timescale 1ns/1ps
`default_nettype none
module sfc_link_props
	import sfc_pkg::*;
	(
	input wire logic        clk,
	input wire logic        RST,
	input wire logic        op_valid,
	input wire sfc_op_e     op_code,
	input wire sfc_frame_s  op_frame,
	input wire logic [5:0]  op_qp,
	input wire logic        op_ready,
	input wire logic        op_done,
	input wire logic        op_fault,
	input wire logic        acc_valid,
	input wire logic        acc_write,
	input wire logic [6:0]  acc_idx,
	input wire logic        acc_done,
	input wire logic        acc_fault,
	input wire logic        eng_req,
	input wire sfc_eng_e    eng_kind,
	input wire logic [15:0] eng_bytes,
	input wire logic        eng_done,
	input wire logic [15:0] load_count,
	input wire sfc_frame_s  cur,
	input wire sfc_frame_s  saved
	);
	// Op taken; stacked write past the frame
	logic tk, wr_out;
	assign tk = op_valid && op_ready;
	assign wr_out = acc_valid && acc_write && acc_idx >= 7'h20 && (acc_idx - 7'h20) >= cur.sof;

	default clocking @(posedge clk); endclocking
	default disable iff (RST);

	// ----------------------------------------------------------------
	// Frame operations
	// ----------------------------------------------------------------
	call_frame_a: assert property (tk && op_code == SFC_OP_CALL |=>
		cur.sof == $past(cur.sof) - $past(cur.sol) && cur.sol == 7'h00) else $error("call frame");
	call_save_a: assert property (tk && op_code == SFC_OP_CALL |=> saved == $past(cur))
		else $error("call save");
	ret_restore_a: assert property (tk && op_code == SFC_OP_RET |=> cur == $past(saved))
		else $error("ret restore");
	cover_empty_a: assert property (tk && op_code == SFC_OP_COVER |=> cur == '0)
		else $error("cover frame");
	alloc_pred_a: assert property (tk && op_code == SFC_OP_ALLOC && op_qp != 6'h00 |=>
		op_done && op_fault && $stable(cur)) else $error("alloc pred");
	alloc_set_a: assert property (tk && op_code == SFC_OP_ALLOC && op_qp == 6'h00 &&
		op_frame.sol <= op_frame.sof && op_frame.sof <= 7'h60 |=> !op_fault && cur == $past(op_frame))
		else $error("alloc frame");
	frame_hold_a: assert property (!tk |=> $stable(cur))
		else $error("frame hold");
	quick_done_a: assert property (tk && !(op_code inside {SFC_OP_FLUSH, SFC_OP_LOAD}) |-> ##1 op_done)
		else $error("quick done");
	// ----------------------------------------------------------------
	// Accesses and engine
	// ----------------------------------------------------------------
	out_write_a: assert property (wr_out && !tk |=> acc_done && acc_fault)
		else $error("out write");
	flush_spill_a: assert property (tk && op_code == SFC_OP_FLUSH |=> eng_req && eng_kind == SFC_ENG_SPILL)
		else $error("flush spill");
	load_fill_a: assert property (tk && op_code == SFC_OP_LOAD |=>
		eng_req && eng_kind == SFC_ENG_FILL && eng_bytes == $past(load_count)) else $error("load fill");
	eng_stall_a: assert property (eng_req && !eng_done |=> !op_done)
		else $error("engine stall");
	eng_end_a: assert property (eng_req && eng_done |=> op_done)
		else $error("engine end");

	cover property (tk && op_code == SFC_OP_CALL);
	cover property (tk && op_code == SFC_OP_RET);
	cover property (eng_req && eng_done);
endmodule // sfc_link_props
`default_nettype wire

// *** dv/tb.sv ***
// Purpose: Bench joining issue end and frame control end
// Assumes: Stand-in engine answers after eng_wait cycles
// Notes:   Table rows first, then reset, renaming and engine cases
`timescale 1ns/1ps
`default_nettype none
module tb;
	import sfc_pkg::*;
	typedef struct packed {
		logic [2:0] op;
		logic [6:0] sof, sol;
		logic [5:0] qp;
		logic [6:0] esof, esol;
		logic       ef;
	} sfc_row_s;
	logic        mclk, rst, ce, wb_we, wb_stb, wb_cyc, wb_ack, eng_req, eng_kind, eng_done;
	logic        exp_kind, chk_bytes;
	logic [31:0] wb_adr, wb_wdat, wb_rdat, rd;
	logic [3:0]  wb_sel;
	logic [15:0] eng_bytes, exp_bytes;
	int          err_total, n_tests, eng_wait, eng_cnt, n_eng, i;
	sfc_row_s    rows [0:10] = '{
		'{3'h0, 7'h14, 7'h08, 6'h00, 7'h14, 7'h08, 1'b0}, '{3'h0, 7'h60, 7'h60, 6'h00, 7'h60, 7'h60, 1'b0},
		'{3'h0, 7'h61, 7'h00, 6'h00, 7'h60, 7'h60, 1'b1}, '{3'h0, 7'h0a, 7'h0c, 6'h00, 7'h60, 7'h60, 1'b1},
		'{3'h0, 7'h1e, 7'h0a, 6'h05, 7'h60, 7'h60, 1'b1}, '{3'h0, 7'h1e, 7'h0a, 6'h00, 7'h1e, 7'h0a, 1'b0},
		'{3'h1, 7'h00, 7'h00, 6'h00, 7'h14, 7'h00, 1'b0}, '{3'h0, 7'h19, 7'h05, 6'h00, 7'h19, 7'h05, 1'b0},
		'{3'h2, 7'h00, 7'h00, 6'h00, 7'h1e, 7'h0a, 1'b0}, '{3'h3, 7'h00, 7'h00, 6'h00, 7'h00, 7'h00, 1'b0},
		'{3'h6, 7'h00, 7'h00, 6'h00, 7'h00, 7'h00, 1'b0}};

	sfc_link_if i_sfc_link_if (.clk(mclk));
	sfc_frame_dev #(.PHYS_N(7'h60)) i_sfc_frame_dev (.MCLK(mclk), .RST(rst), .CE(ce),
		.LINK(i_sfc_link_if.dev), .PHYS_ADDR(), .PHYS_STACKED(), .PHYS_WE(), .PHYS_RE());
	sfc_issue_host i_sfc_issue_host (.MCLK(mclk), .RST(rst), .CE(ce), .WB_ADR_I(wb_adr),
		.WB_DAT_I(wb_wdat), .WB_DAT_O(wb_rdat), .WB_SEL_I(wb_sel), .WB_WE_I(wb_we),
		.WB_STB_I(wb_stb), .WB_CYC_I(wb_cyc), .WB_ACK_O(wb_ack), .ENG_REQ(eng_req),
		.ENG_KIND(eng_kind), .ENG_BYTES(eng_bytes), .ENG_DONE(eng_done), .LINK(i_sfc_link_if.ctl));
	sfc_link_props i_sfc_link_props (.clk(mclk), .RST(rst),
		.op_valid(i_sfc_link_if.op_valid), .op_code(i_sfc_link_if.op_code),
		.op_frame(i_sfc_link_if.op_frame), .op_qp(i_sfc_link_if.op_qp),
		.op_ready(i_sfc_link_if.op_ready), .op_done(i_sfc_link_if.op_done),
		.op_fault(i_sfc_link_if.op_fault), .acc_valid(i_sfc_link_if.acc_valid),
		.acc_write(i_sfc_link_if.acc_write), .acc_idx(i_sfc_link_if.acc_idx),
		.acc_done(i_sfc_link_if.acc_done), .acc_fault(i_sfc_link_if.acc_fault),
		.eng_req(i_sfc_link_if.eng_req), .eng_kind(i_sfc_link_if.eng_kind),
		.eng_bytes(i_sfc_link_if.eng_bytes), .eng_done(i_sfc_link_if.eng_done),
		.load_count(i_sfc_link_if.load_count), .cur(i_sfc_link_if.cur), .saved(i_sfc_link_if.saved));

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic end_of_test;
		if (err_total == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Classic cycle; data taken at the ack edge
	task automatic wb(input logic w, input logic [2:0] a, input logic [31:0] d, input logic [3:0] s);
		int k = 0;
		{wb_cyc, wb_stb, wb_we, wb_adr, wb_wdat, wb_sel} <= {2'b11, w, 27'h0, a, 2'h0, d, s};
		do begin
			@(posedge mclk);
			k++;
		end while (wb_ack !== 1'b1 && k < 20);
		if (wb_ack !== 1'b1) begin
			err_total++;
			end_of_test;
		end
		rd = wb_rdat;
		{wb_cyc, wb_stb} <= 2'b00;
		@(posedge mclk);
	endtask

	task automatic rdw(input logic [2:0] a);
		wb(1'b0, a, 32'h0, 4'hf);
	endtask

	// Poll status until not busy
	task automatic idle;
		int k = 0;
		do begin
			rdw(3'h1);
			k++;
		end while (rd[0] !== 1'b0 && k < 40);
		if (rd[0] !== 1'b0) begin
			err_total++;
			end_of_test;
		end
	endtask

	task automatic op(input logic [2:0] c, input logic [6:0] f, input logic [6:0] l, input logic [5:0] q);
		wb(1'b1, 3'h0, {6'h0, q, 1'b0, l, 1'b0, f, 1'b0, c}, 4'hf);
		idle;
	endtask

	// Access write, then readback
	task automatic acc(input logic [6:0] idx, input logic [6:0] ep, input logic ef);
		wb(1'b1, 3'h3, {23'h0, 1'b1, 1'b0, idx}, 4'hf);
		rdw(3'h3);
		chk("acc fault", 32'(rd[9]), 32'(ef));
		if (!ef) chk("acc phys", 32'(rd[6:0]), 32'(ep));
	endtask

	// ----------------------------------------------------------------
	// Clock, watchdog and engine stand-in
	// ----------------------------------------------------------------
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	initial begin
		repeat (50000) @(posedge mclk);
		err_total++;
		end_of_test;
	end

	// Engine stand-in
	always @(posedge mclk) begin
		if (eng_req && !eng_done) begin
			if (eng_cnt == 0) begin
				n_eng++;
				chk("eng kind", 32'(eng_kind), 32'(exp_kind));
				if (chk_bytes) chk("eng bytes", 32'(eng_bytes), 32'(exp_bytes));
			end
			if (eng_cnt >= eng_wait) begin
				eng_done <= 1'b1;
				eng_cnt = 0;
			end else begin
				eng_cnt++;
			end
		end else begin
			eng_done <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		{rst, ce, wb_we, wb_stb, wb_cyc, eng_done, exp_kind, chk_bytes} = 8'hc0;
		{wb_adr, wb_wdat, wb_sel, exp_bytes} = '0;
		{err_total, n_tests, eng_wait, eng_cnt, n_eng} = '0;
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		for (i = 0; i < 11; i++) begin
			op(rows[i].op, rows[i].sof, rows[i].sol, rows[i].qp);
			chk("row frame", 32'({rd[22:16], rd[14:8], rd[1]}), 32'({rows[i].esol, rows[i].esof, rows[i].ef}));
		end
		// Mid-run reset, defaults, byte select
		rst <= 1'b1;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		rdw(3'h1);
		chk("status reset", rd, 32'h0);
		rdw(3'h4);
		chk("saved reset", rd, 32'h0);
		rdw(3'h7);
		chk("unmapped", rd, 32'h0);
		wb(1'b1, 3'h2, 32'h0000abcd, 4'h1);
		rdw(3'h2);
		chk("cfg sel", rd, 32'h000000cd);
		// Renaming across call, alloc and return
		op(3'h0, 7'h1e, 7'h0a, 6'h00);
		acc(7'h2a, 7'h0a, 1'b0);
		acc(7'h3d, 7'h1d, 1'b0);
		acc(7'h3e, 7'h00, 1'b1);
		acc(7'h05, 7'h05, 1'b0);
		op(3'h1, 7'h00, 7'h00, 6'h00);
		chk("call frame", 32'({rd[22:16], rd[14:8]}), 32'({7'h00, 7'h14}));
		rdw(3'h4);
		chk("call saved", 32'({rd[18:12], rd[10:4]}), 32'({7'h0a, 7'h1e}));
		acc(7'h20, 7'h0a, 1'b0);
		acc(7'h34, 7'h00, 1'b1);
		op(3'h0, 7'h60, 7'h5a, 6'h00);
		acc(7'h20, 7'h0a, 1'b0);
		op(3'h1, 7'h00, 7'h00, 6'h00);
		acc(7'h20, 7'h04, 1'b0);
		acc(7'h25, 7'h09, 1'b0);
		op(3'h2, 7'h00, 7'h00, 6'h00);
		chk("ret frame", 32'({rd[22:16], rd[14:8]}), 32'({7'h5a, 7'h60}));
		acc(7'h20, 7'h0a, 1'b0);
		op(3'h7, 7'h1e, 7'h0a, 6'h00);
		op(3'h2, 7'h00, 7'h00, 6'h00);
		chk("ret restored", 32'({rd[22:16], rd[14:8]}), 32'({7'h0a, 7'h1e}));
		acc(7'h2a, 7'h0a, 1'b0);
		// Slow flush: busy through the stall
		eng_wait = 20;
		wb(1'b1, 3'h0, 32'h4, 4'hf);
		rdw(3'h1);
		chk("flush busy", 32'(rd[0]), 32'h1);
		idle;
		// Load with count, then zero count
		{exp_kind, chk_bytes, exp_bytes} = {2'b11, 16'h0040};
		eng_wait = 0;
		wb(1'b1, 3'h2, 32'h00000040, 4'hf);
		op(3'h5, 7'h00, 7'h00, 6'h00);
		chk("load fault", 32'(rd[1]), 32'h0);
		exp_bytes = 16'h0000;
		eng_wait = 3;
		wb(1'b1, 3'h2, 32'h0, 4'hf);
		op(3'h5, 7'h00, 7'h00, 6'h00);
		chk("engine runs", 32'(n_eng), 32'h3);
		end_of_test;
	end
endmodule // tb
`default_nettype wire
